// ---- tb_top.sv ----
// self-checking bench for the usb status and activity indicator block
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [3:0] cfg_tab [7] = '{4'h2, 4'hA, 4'h0, 4'h8, 4'h4, 4'h1, 4'h9};
    localparam logic [6:0] exp_tab = 7'h59;
    logic clk_sys, resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic quiet, brst_req, vbus_on, ext_low;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] busy;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire usb_bus_reset, usb_line_activity, bus_power_detect_in, dp_pullup_en, usb_suspended, core_reset;
    wire pri, sec, tx_o, tx_oe, tx_pu, rx_o, rx_oe, rx_pu, rp_o, rp_oe;
    wire [1:0] ind = {rx_o, tx_o};
    wire tx_pad = tx_oe ? tx_o : tx_pu; // undriven pad sits at its pull-up level
    wire rx_pad = rx_oe ? rx_o : rx_pu;
    wire rp_in = !(rp_oe && !rp_o) && !ext_low; // open-drain wire with pull-up
    int err_total, checked, n;

    usbsi_top #(.IDLE_SUSP_CYC(50), .IND_HALF_CYC(8), .RST_MIN_CYC(5)) usbsi_top_inst (
        .clk_sys, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .usb_bus_reset, .usb_line_activity, .usb_configured(1'b0), .bus_power_detect_in,
        .dp_pullup_en, .usb_suspended, .usb_condition_out_primary(pri), .usb_condition_out_secondary(sec),
        .uart_tx_busy(busy[0]), .uart_rx_busy(busy[1]), .tx_activity_indicator_a_in(tx_pad),
        .tx_activity_indicator_a_out(tx_o), .tx_activity_indicator_a_oe(tx_oe),
        .tx_activity_indicator_a_pullup(tx_pu), .rx_activity_indicator_a_in(rx_pad),
        .rx_activity_indicator_a_out(rx_o), .rx_activity_indicator_a_oe(rx_oe),
        .rx_activity_indicator_a_pullup(rx_pu), .reset_pin_in(rp_in), .reset_pin_out(rp_o),
        .reset_pin_oe(rp_oe), .core_reset);
    usbsi_host_model #(.FRAME_GAP(4)) usbsi_host_model_inst (
        .clk_sys, .resetn, .quiet, .brst_req, .vbus_on, .usb_bus_reset, .usb_line_activity, .bus_power_detect_in);

    // free-running system clock
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    task automatic close_out;
        if (err_total == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("Error at %0t: got %h exp %h", $time, g, e);
        end
    endtask

    // write: address and data offered together, each dropped once taken; one spare edge at the end
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic done;
        done = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        // a local flag: the ready just scheduled is not yet visible in this time step
        while (!done) begin
            @(posedge clk_sys);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                s_axi_bready <= 1'b0;
                chk(s_axi_bresp, er);
                done = 1'b1;
            end
        end
        @(posedge clk_sys);
    endtask

    // read with expected data and response; one spare edge at the end
    task automatic axr(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        logic done;
        done = 1'b0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!done) begin
            @(posedge clk_sys);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                s_axi_rready <= 1'b0;
                chk(s_axi_rdata, e);
                chk(s_axi_rresp, er);
                done = 1'b1;
            end
        end
        @(posedge clk_sys);
    endtask

    // counts indicator edges between consecutive samples
    task automatic tick(input int j);
        logic v;
        v = ind[j];
        @(posedge clk_sys);
        if (ind[j] !== v) n++;
    endtask

    // pulls the reset pin low for len cycles and counts core reset cycles over that span and 12 cycles more
    task automatic pin_pulse(input int len);
        n = 0;
        ext_low <= 1'b1;
        for (int k = 1; k <= len + 12; k++) begin
            @(posedge clk_sys);
            if (k == len) ext_low <= 1'b0;
            n += core_reset;
        end
    endtask

    // main sequence
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        {quiet, brst_req, ext_low, s_axi_awaddr, s_axi_araddr, s_axi_wdata, busy} = '0;
        vbus_on = 1'b1;
        s_axi_wstrb = 4'hF;
        err_total = 0;
        checked = 0;
        resetn = 1'b0;
        repeat (8) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (2) @(posedge clk_sys);
        chk({rp_oe, rp_o}, 2'h2);
        chk({tx_oe, tx_pu, rx_oe, rx_pu, pri, sec}, 6'h15);
        axr(8'h00, 32'h2, 2'h0);
        axr(8'h04, 32'hA, 2'h0);
        axr(8'h08, 32'h0, 2'h0);
        axr(8'h14, 32'h32, 2'h0);
        axr(8'h18, 32'h0, 2'h2);
        axw(8'h18, 32'hF, 2'h2);
        vbus_on <= 1'b0;
        repeat (3) @(posedge clk_sys);
        chk(dp_pullup_en, 1'b0);
        vbus_on <= 1'b1;
        repeat (3) @(posedge clk_sys);
        chk(dp_pullup_en, 1'b1);
        quiet <= 1'b1;
        repeat (60) @(posedge clk_sys);
        chk({usb_suspended, pri, sec}, 3'h6);
        axr(8'h10, 32'h3B, 2'h0);
        for (int i = 0; i < 7; i++) begin
            axw(8'h00, {28'h0, cfg_tab[i]}, 2'h0);
            chk(pri, exp_tab[i]);
        end
        quiet <= 1'b0;
        repeat (8) @(posedge clk_sys);
        chk({usb_suspended, sec}, 2'h1);
        axw(8'h00, 32'h4, 2'h0);
        for (int m = 0; m < 2; m++) begin
            axw(8'h14, 32'h32 + m, 2'h0);
            axw(8'h0C, 32'h0, 2'h0);
            chk(pri, 1'b1);
            axw(8'h0C, 32'h2, 2'h0);
            chk(pri, 1'b0);
        end
        // a write with no byte lanes enabled must leave the register alone
        s_axi_wstrb <= 4'h0;
        axw(8'h14, 32'h77, 2'h0);
        s_axi_wstrb <= 4'hF;
        axr(8'h14, 32'h33, 2'h0);
        axw(8'h00, 32'h1, 2'h0);
        brst_req <= 1'b1;
        repeat (4) @(posedge clk_sys);
        chk({pri, rp_oe, rp_o}, 3'h6);
        repeat (6) @(posedge clk_sys);
        brst_req <= 1'b0;
        repeat (30) @(posedge clk_sys);
        chk({pri, rp_oe}, 2'h0);
        axr(8'h0C, 32'h0, 2'h0);
        axw(8'h0C, 32'h1, 2'h0);
        chk(rp_oe, 1'b1);
        repeat (20) @(posedge clk_sys);
        axw(8'h08, 32'h3, 2'h0);
        chk({tx_oe, tx_pu, rx_oe, rx_pu}, 4'hA);
        for (int j = 0; j < 2; j++) begin
            n = 0;
            busy[j] <= 1'b1;
            repeat (36) tick(j);
            busy[j] <= 1'b0;
            repeat (20) tick(j);
            chk(n, 4);
        end
        pin_pulse(3);
        chk(n, 0);
        pin_pulse(8);
        chk(n != 0, 1'b1);
        close_out();
    end

    // watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge clk_sys);
        err_total++;
        close_out();
    end
endmodule // tb_top

bind usbsi_top usbsi_monitor #(.IDLE_SUSP_CYC(IDLE_SUSP_CYC)) usbsi_monitor_inst (
    .clk_sys, .resetn, .bus_power_detect_in, .dp_pullup_en, .usb_bus_reset, .usb_line_activity,
    .usb_suspended, .uart_tx_busy, .tx_activity_indicator_a_out, .tx_activity_indicator_a_oe,
    .tx_activity_indicator_a_pullup, .reset_pin_out, .reset_pin_oe, .core_reset);

// ---- usbsi_defs.vh ----
// constants for the usb status and activity indicator block
`ifndef USBSI_DEFS_VH
`define USBSI_DEFS_VH

// register byte addresses
`define USBSI_ADDR_PRI_CFG     8'h00
`define USBSI_ADDR_SEC_CFG     8'h04
`define USBSI_ADDR_PIN_SEL     8'h08
`define USBSI_ADDR_CTRL        8'h0C
`define USBSI_ADDR_STATUS      8'h10
`define USBSI_ADDR_MAXPWR      8'h14

// condition pin config fields: [0] bus reset, [1] suspend, [2] power unsafe, [3] active low
`define USBSI_CFG_RST_BIT      0
`define USBSI_CFG_SUSP_BIT     1
`define USBSI_CFG_PWR_BIT      2
`define USBSI_CFG_POL_BIT      3
`define USBSI_PRI_CFG_RESET    4'h2
`define USBSI_SEC_CFG_RESET    4'hA

// control register fields
`define USBSI_CTRL_SWRST_BIT   0
`define USBSI_CTRL_CONFIG_BIT  1

// max power threshold between low and high power devices
`define USBSI_MAXPWR_LOW_LIMIT 8'h32
`define USBSI_MAXPWR_RESET     8'h32

// timing
`define USBSI_CLK_MHZ          250
`define USBSI_CORE_MHZ         48
`define USBSI_IND_HZ           10
`define USBSI_IDLE_SUSP_US     3000
`define USBSI_RST_MIN_NS       15000
`define USBSI_RSTOUT_CYC       16

`endif

// ---- usbsi_host_model.sv ----
// usb host side model: frame traffic, bus reset signalling and bus power
module usbsi_host_model #(
    parameter int FRAME_GAP = 4
) (
    input  logic clk_sys,
    input  logic resetn,
    input  logic quiet,
    input  logic brst_req,
    input  logic vbus_on,
    output logic usb_bus_reset,
    output logic usb_line_activity,
    output logic bus_power_detect_in
);
    timeunit 1ns;
    timeprecision 100ps;
    int gap_q;

    // one frame marker per gap; a quiet host sends nothing, which lets the device suspend
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            gap_q <= 0;
            usb_line_activity <= 1'b0;
            usb_bus_reset <= 1'b0;
            bus_power_detect_in <= 1'b1;
        end else begin
            gap_q <= (gap_q == FRAME_GAP - 1) ? 0 : gap_q + 1;
            usb_line_activity <= !quiet && gap_q == 0;
            usb_bus_reset <= brst_req;
            bus_power_detect_in <= vbus_on;
        end
    end
endmodule // usbsi_host_model

// ---- usbsi_monitor.sv ----
// assertion checker for the usb status and activity indicator block
module usbsi_monitor #(
    parameter int IDLE_SUSP_CYC = 50
) (
    input logic clk_sys,
    input logic resetn,
    input logic bus_power_detect_in,
    input logic dp_pullup_en,
    input logic usb_bus_reset,
    input logic usb_line_activity,
    input logic usb_suspended,
    input logic uart_tx_busy,
    input logic tx_activity_indicator_a_out,
    input logic tx_activity_indicator_a_oe,
    input logic tx_activity_indicator_a_pullup,
    input logic reset_pin_out,
    input logic reset_pin_oe,
    input logic core_reset
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [31:0] idle_q;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    // quiet bus cycle count; anything that keeps the device awake clears it
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn)
            idle_q <= 32'h0;
        else if (usb_line_activity || usb_bus_reset || !bus_power_detect_in || core_reset)
            idle_q <= 32'h0;
        else if (idle_q != 32'hFFFFFFFF)
            idle_q <= idle_q + 32'h1; // saturate so a long stall never wraps to zero
    end

    pullup_follow_a: assert property (dp_pullup_en == bus_power_detect_in)
        else $error("pull-up enable does not follow bus power");
    reset_open_drain_a: assert property (reset_pin_oe |-> !reset_pin_out)
        else $error("reset pin driven high");
    reset_stretch_a: assert property ($fell(reset_pin_oe) |-> $past(reset_pin_oe, 15))
        else $error("reset pin pulse too short");
    bus_reset_pin_a: assert property ($rose(usb_bus_reset) |-> ##[1:3] reset_pin_oe)
        else $error("bus reset did not drive the reset pin");
    suspend_wake_a: assert property (usb_line_activity |=> !usb_suspended)
        else $error("suspend held through bus activity");
    suspend_late_a: assert property (idle_q > IDLE_SUSP_CYC + 2 |-> usb_suspended)
        else $error("suspend missing after idle span");
    suspend_early_a: assert property (idle_q + 2 < IDLE_SUSP_CYC |-> !usb_suspended)
        else $error("suspend entered too early");
    indicator_hold_a: assert property (!uart_tx_busy && !core_reset |=> $stable(tx_activity_indicator_a_out))
        else $error("indicator moved while idle");
    pin_pull_mode_a: assert property (tx_activity_indicator_a_oe |-> !tx_activity_indicator_a_pullup)
        else $error("pull-up left on a driven pin");
endmodule // usbsi_monitor

// ---- usbsi_top.v ----
// usb status outputs, activity indicators, reset pin and pull-up control
//
// Implementation choices: the register addresses and the AXI4-Lite slave port.
`include "usbsi_defs.vh"

module usbsi_top #(
    parameter IDLE_SUSP_CYC = `USBSI_IDLE_SUSP_US * `USBSI_CLK_MHZ,
    parameter IND_HALF_CYC  = `USBSI_CLK_MHZ * 1000000 / (2 * `USBSI_IND_HZ),
    parameter RST_MIN_CYC   = (`USBSI_RST_MIN_NS * `USBSI_CLK_MHZ + 999) / 1000
) (
    input  wire        clk_sys,
    input  wire        resetn,
    // axi4-lite slave
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output wire [1:0]  s_axi_bresp,
    output wire        s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output wire [1:0]  s_axi_rresp,
    output wire        s_axi_rvalid,
    input  wire        s_axi_rready,
    // usb side status from the protocol engine
    input  wire        usb_bus_reset,
    input  wire        usb_line_activity,
    input  wire        usb_configured,
    input  wire        bus_power_detect_in,
    output wire        dp_pullup_en,
    output wire        usb_suspended,
    output wire        usb_condition_out_primary,
    output wire        usb_condition_out_secondary,
    // uart activity
    input  wire        uart_tx_busy,
    input  wire        uart_rx_busy,
    // multifunction pins
    input  wire        tx_activity_indicator_a_in,
    output wire        tx_activity_indicator_a_out,
    output wire        tx_activity_indicator_a_oe,
    output wire        tx_activity_indicator_a_pullup,
    input  wire        rx_activity_indicator_a_in,
    output wire        rx_activity_indicator_a_out,
    output wire        rx_activity_indicator_a_oe,
    output wire        rx_activity_indicator_a_pullup,
    // open-drain reset pin
    input  wire        reset_pin_in,
    output wire        reset_pin_out,
    output wire        reset_pin_oe,
    output wire        core_reset
);

    localparam [31:0] IDLE_W = IDLE_SUSP_CYC;
    localparam [31:0] HALF_W = IND_HALF_CYC;
    localparam [31:0] RMIN_W = RST_MIN_CYC;
    localparam [7:0]  RST_OUT_CYC = `USBSI_RSTOUT_CYC;
    // core rate kept for reference only; the idle, indicator and pin-filter counts above derive from the 250 MHz fabric clock, which stands in for the 48 MHz core
    localparam [7:0]  CORE_MHZ = `USBSI_CORE_MHZ;

    // register state
    reg  [3:0]  pri_cfg_q;
    reg  [3:0]  sec_cfg_q;
    reg  [1:0]  pin_sel_q;
    reg         cfg_done_q;
    reg  [7:0]  maxpwr_q;
    reg         swrst_q;

    // axi channel state
    reg         aw_full_q;
    reg  [7:0]  aw_addr_q;
    reg         w_full_q;
    reg  [31:0] w_data_q;
    reg  [3:0]  w_strb_q;
    reg         bvalid_q;
    reg         bresp_err_q;
    reg         rvalid_q;
    reg         rresp_err_q;

    // status machinery
    reg  [31:0] idle_cnt_q;
    reg         susp_q;
    reg  [31:0] tx_cnt_q;
    reg  [31:0] rx_cnt_q;
    reg         tx_lvl_q;
    reg         rx_lvl_q;
    reg         rst_s1_q;
    reg         rst_s2_q;
    reg  [31:0] rst_lo_cnt_q;
    reg         ext_rst_q;
    reg  [7:0]  rst_out_cnt_q;
    reg         bus_rst_q;

    // selected conditions and polarity for one status output
    function cond_drive;
        input [3:0] cfg;
        input       brst;
        input       susp;
        input       unsafe;
        reg         hit;
        begin
            hit = (cfg[`USBSI_CFG_RST_BIT] & brst) |
                  (cfg[`USBSI_CFG_SUSP_BIT] & susp) |
                  (cfg[`USBSI_CFG_PWR_BIT] & unsafe);
            cond_drive = hit ^ cfg[`USBSI_CFG_POL_BIT];
        end
    endfunction

    // byte-lane merge of a write into a narrow register
    function [31:0] lane_merge;
        input [31:0] old;
        input [31:0] data;
        input [3:0]  strb;
        integer      i;
        begin
            lane_merge = old;
            for (i = 0; i < 4; i = i + 1) begin
                if (strb[i]) begin
                    lane_merge[i*8 +: 8] = data[i*8 +: 8];
                end
            end
        end
    endfunction

    wire        high_power;
    wire        pwr_unsafe;
    wire        wr_fire = aw_full_q & w_full_q & ~bvalid_q;
    wire        rd_fire = s_axi_arvalid & ~rvalid_q;
    wire [31:0] pri_m   = lane_merge({28'h0000000, pri_cfg_q}, w_data_q, w_strb_q);
    wire [31:0] sec_m   = lane_merge({28'h0000000, sec_cfg_q}, w_data_q, w_strb_q);
    wire [31:0] sel_m   = lane_merge({30'h0000000, pin_sel_q}, w_data_q, w_strb_q);
    wire [31:0] ctl_m   = lane_merge({30'h0000000, cfg_done_q, 1'b0}, w_data_q, w_strb_q);
    wire [31:0] pwr_m   = lane_merge({24'h000000, maxpwr_q}, w_data_q, w_strb_q);

    // hold address and data apart so either may arrive first
    assign s_axi_awready = ~aw_full_q;
    assign s_axi_wready  = ~w_full_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_err_q ? 2'h2 : 2'h0;
    assign s_axi_arready = ~rvalid_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rresp   = rresp_err_q ? 2'h2 : 2'h0;

    // internal reset sources: software pulse, bus reset, filtered pin reset
    wire int_rst = swrst_q | bus_rst_q | ext_rst_q;
    assign core_reset = int_rst | (rst_out_cnt_q != 8'h00);

    // write channel and register updates
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            aw_full_q   <= 1'b0;
            aw_addr_q   <= 8'h00;
            w_full_q    <= 1'b0;
            w_data_q    <= 32'h00000000;
            w_strb_q    <= 4'h0;
            bvalid_q    <= 1'b0;
            bresp_err_q <= 1'b0;
            pri_cfg_q   <= `USBSI_PRI_CFG_RESET;
            sec_cfg_q   <= `USBSI_SEC_CFG_RESET;
            pin_sel_q   <= 2'h0;
            cfg_done_q  <= 1'b0;
            maxpwr_q    <= `USBSI_MAXPWR_RESET;
            swrst_q     <= 1'b0;
        end else begin
            swrst_q <= 1'b0;
            if (s_axi_awvalid && !aw_full_q) begin
                aw_full_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_full_q) begin
                w_full_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_full_q   <= 1'b0;
                w_full_q    <= 1'b0;
                bvalid_q    <= 1'b1;
                bresp_err_q <= 1'b0;
                case (aw_addr_q)
                    `USBSI_ADDR_PRI_CFG: pri_cfg_q <= pri_m[3:0];
                    `USBSI_ADDR_SEC_CFG: sec_cfg_q <= sec_m[3:0];
                    `USBSI_ADDR_PIN_SEL: pin_sel_q <= sel_m[1:0];
                    `USBSI_ADDR_CTRL: begin
                        cfg_done_q <= ctl_m[`USBSI_CTRL_CONFIG_BIT];
                        swrst_q    <= ctl_m[`USBSI_CTRL_SWRST_BIT];
                    end
                    `USBSI_ADDR_MAXPWR: maxpwr_q <= pwr_m[7:0];
                    `USBSI_ADDR_STATUS: bresp_err_q <= 1'b0;
                    default: bresp_err_q <= 1'b1;
                endcase
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
            // a bus reset drops the configured state, as enumeration starts again
            if (usb_bus_reset) begin
                cfg_done_q <= 1'b0;
            end
        end
    end

    // read channel: one cycle from address to data
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rvalid_q    <= 1'b0;
            rresp_err_q <= 1'b0;
            s_axi_rdata <= 32'h00000000;
        end else if (rd_fire) begin
            rvalid_q    <= 1'b1;
            rresp_err_q <= 1'b0;
            case (s_axi_araddr)
                `USBSI_ADDR_PRI_CFG: s_axi_rdata <= {28'h0000000, pri_cfg_q};
                `USBSI_ADDR_SEC_CFG: s_axi_rdata <= {28'h0000000, sec_cfg_q};
                `USBSI_ADDR_PIN_SEL: s_axi_rdata <= {30'h0000000, pin_sel_q};
                `USBSI_ADDR_CTRL:    s_axi_rdata <= {30'h0000000, cfg_done_q, 1'b0};
                `USBSI_ADDR_STATUS:  s_axi_rdata <= {26'h000000, bus_power_detect_in, pwr_unsafe,
                                                     susp_q, bus_rst_q, rx_lvl_q, tx_lvl_q};
                `USBSI_ADDR_MAXPWR:  s_axi_rdata <= {24'h000000, maxpwr_q};
                default: begin
                    s_axi_rdata <= 32'h00000000;
                    rresp_err_q <= 1'b1;
                end
            endcase
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // suspend detect: quiet bus for the idle time
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            idle_cnt_q <= 32'h00000000;
            susp_q     <= 1'b0;
            bus_rst_q  <= 1'b0;
        end else begin
            bus_rst_q <= usb_bus_reset;
            if (usb_line_activity || usb_bus_reset || !bus_power_detect_in) begin
                idle_cnt_q <= 32'h00000000;
                susp_q     <= 1'b0;
            end else if (idle_cnt_q >= IDLE_W - 32'h00000001) begin
                susp_q <= 1'b1;
            end else begin
                idle_cnt_q <= idle_cnt_q + 32'h00000001;
            end
        end
    end

    // power-unsafe: same answer whether max power is low or high class
    assign high_power = maxpwr_q > `USBSI_MAXPWR_LOW_LIMIT;
    assign pwr_unsafe = high_power ? (susp_q | ~cfg_done_q) : (susp_q | ~cfg_done_q);

    assign usb_suspended = susp_q;
    assign usb_condition_out_primary   = cond_drive(pri_cfg_q, bus_rst_q, susp_q, pwr_unsafe);
    assign usb_condition_out_secondary = cond_drive(sec_cfg_q, bus_rst_q, susp_q, pwr_unsafe);
    assign dp_pullup_en = bus_power_detect_in;

    // activity toggles; counters clear and level holds once idle
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            tx_cnt_q <= 32'h00000000;
            rx_cnt_q <= 32'h00000000;
            tx_lvl_q <= 1'b1;
            rx_lvl_q <= 1'b1;
        end else begin
            if (!uart_tx_busy) begin
                tx_cnt_q <= 32'h00000000;
            end else if (tx_cnt_q >= HALF_W - 32'h00000001) begin
                tx_cnt_q <= 32'h00000000;
                tx_lvl_q <= ~tx_lvl_q;
            end else begin
                tx_cnt_q <= tx_cnt_q + 32'h00000001;
            end
            if (!uart_rx_busy) begin
                rx_cnt_q <= 32'h00000000;
            end else if (rx_cnt_q >= HALF_W - 32'h00000001) begin
                rx_cnt_q <= 32'h00000000;
                rx_lvl_q <= ~rx_lvl_q;
            end else begin
                rx_cnt_q <= rx_cnt_q + 32'h00000001;
            end
        end
    end

    // pins stay gpio inputs with pull-up until the indicator function is chosen
    assign tx_activity_indicator_a_out    = tx_lvl_q;
    assign tx_activity_indicator_a_oe     = pin_sel_q[0];
    assign tx_activity_indicator_a_pullup = ~pin_sel_q[0];
    assign rx_activity_indicator_a_out    = rx_lvl_q;
    assign rx_activity_indicator_a_oe     = pin_sel_q[1];
    assign rx_activity_indicator_a_pullup = ~pin_sel_q[1];

    // reset pin filter; our own drive is masked so we never retrigger on ourselves
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rst_s1_q      <= 1'b1;
            rst_s2_q      <= 1'b1;
            rst_lo_cnt_q  <= 32'h00000000;
            ext_rst_q     <= 1'b0;
            rst_out_cnt_q <= RST_OUT_CYC;
        end else begin
            rst_s1_q  <= reset_pin_in;
            rst_s2_q  <= rst_s1_q;
            ext_rst_q <= 1'b0;
            if (rst_s2_q || reset_pin_oe) begin
                rst_lo_cnt_q <= 32'h00000000;
            end else if (rst_lo_cnt_q == RMIN_W - 32'h00000001) begin
                rst_lo_cnt_q <= rst_lo_cnt_q + 32'h00000001;
                ext_rst_q    <= 1'b1;
            end else if (rst_lo_cnt_q < RMIN_W) begin
                rst_lo_cnt_q <= rst_lo_cnt_q + 32'h00000001;
            end
            if (swrst_q || bus_rst_q) begin
                rst_out_cnt_q <= RST_OUT_CYC;
            end else if (rst_out_cnt_q != 8'h00) begin
                rst_out_cnt_q <= rst_out_cnt_q - 8'h01;
            end
        end
    end

    // open drain: only ever drive low
    assign reset_pin_out = 1'b0;
    assign reset_pin_oe  = (rst_out_cnt_q != 8'h00);

endmodule // usbsi_top
